// ### core/bclc_chopper.sv
// Purpose: fixed off-time current-limit chopper of a three-phase bridge
// Assumes: 10 MHz sys_clk, avalon-mm slave, async pins on pwm and comparator
// Notes: threshold leaves as a 4-bit code, level = (code+1) x 12.5 mV
//
// Summary of operation
// - degauss compensation is enabled only while its control bit is one.
// - indirect voltage and speed modes: off-time equals programmed bridge pwm period.
// - direct voltage mode: bridge pwm follows pwm input, off-time from field.
// - current mode: while limiting, only fixed off-time sets bridge pwm frequency.
// - comparator flags sense above threshold to pwm control logic.
// - current mode: threshold is measured input duty times full-scale threshold.
// - other modes: threshold code is the four-bit limit field.
// - current mode: duty measured to 8 bits, top 4 bits replace limit field.
// - each pwm cycle starts in drive until sensed current reaches threshold.
// - a trip moves bridge to selected recirculation for the fixed off-time.
// - recirc select: 01 high slow, 10 low slow, 00 auto slow, 11 fast.
// - off-time is 20 us plus n times 1.6 us from the clock.
// - a zero field gives the minimum off-time of 20 us.
// - indirect and speed modes: off-time is the fixed pwm period too.
// - auto recirculation: low then high when bemf falls, reverse when rising.
`timescale 1ns/100ps
module bclc_chopper (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // avalon-mm slave
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  // pins
  input  wire logic                  pwm_pin,
  input  wire logic                  sense_over_pin,
  // commutation controller
  input  wire logic                  comm_run,
  input  wire logic                  bemf_falling,
  input  wire logic                  zc_passed,
  input  wire logic [7:0]            speed_duty,
  // to drivers and analog
  output bclc_pkg::bclc_bridge_t     bridge,
  output logic [3:0]                 limit_code,
  output logic                       demag_comp_enable
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  bclc_pkg::bclc_cfg_t    cfg_ff;
  bclc_pkg::bclc_state_t  state_ff, nxt_state;
  bclc_pkg::bclc_bridge_t bridge_ff, nxt_bridge;
  logic [31:0]            rdata_ff;
  logic                   ack_ff;
  logic                   pwm_s1_ff, pwm_s2_ff, pwm_d_ff;
  logic                   sns_s1_ff, sns_s2_ff;
  logic [3:0]             limit_ff;
  logic [bclc_pkg::TIMER_W-1:0] on_cnt_ff;
  logic [bclc_pkg::TIMER_W+7:0] on_prod;
  logic [bclc_pkg::TIMER_W-1:0] on_len;
  logic [bclc_pkg::TIMER_W-1:0] per_len;
  logic [7:0]             duty;
  logic                   req, wr_go;
  logic                   fixed_mode, direct_mode, current_mode;
  logic                   pwm_rise, pwm_fall;
  logic                   cycle_start, trip, on_over;
  logic                   off_start, off_busy, off_done;
  logic                   per_start, per_busy, per_done;
  logic                   rec_low_auto;

  ////////////////////////////////////////////////////////////////////////
  // avalon slave

  // read data latched in the first cycle, write data and answer one cycle later
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_ff;
  assign wr_go           = avs_write && ack_ff;
  assign avs_readdata    = rdata_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      ack_ff <= 1'b0;
    else
      ack_ff <= req && !ack_ff;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_ff.mode   <= bclc_pkg::RST_MODE;
      cfg_ff.demag  <= 1'b0;
      cfg_ff.recirc <= bclc_pkg::RST_RECIRC;
      cfg_ff.period <= bclc_pkg::RST_PERIOD;
      cfg_ff.limit  <= bclc_pkg::RST_LIMIT;
    end else if (wr_go) begin
      unique case (avs_address)
        bclc_pkg::OFS_CTRL: begin
          cfg_ff.mode   <= avs_writedata[bclc_pkg::CTRL_MODE_LSB +: 2];
          cfg_ff.demag  <= avs_writedata[bclc_pkg::CTRL_DEMAG_BIT];
          cfg_ff.recirc <= avs_writedata[bclc_pkg::CTRL_RECIRC_LSB +: 2];
        end
        bclc_pkg::OFS_CFG: begin
          cfg_ff.period <= avs_writedata[bclc_pkg::CFG_PERIOD_LSB +: 5];
          cfg_ff.limit  <= avs_writedata[bclc_pkg::CFG_LIMIT_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      rdata_ff <= 32'h0000_0000;
      unique case (avs_address)
        bclc_pkg::OFS_CTRL: begin
          rdata_ff[bclc_pkg::CTRL_MODE_LSB +: 2]   <= cfg_ff.mode;
          rdata_ff[bclc_pkg::CTRL_DEMAG_BIT]       <= cfg_ff.demag;
          rdata_ff[bclc_pkg::CTRL_RECIRC_LSB +: 2] <= cfg_ff.recirc;
        end
        bclc_pkg::OFS_CFG: begin
          rdata_ff[bclc_pkg::CFG_PERIOD_LSB +: 5]  <= cfg_ff.period;
          rdata_ff[bclc_pkg::CFG_LIMIT_LSB +: 4]   <= cfg_ff.limit;
        end
        bclc_pkg::OFS_STATUS: begin
          rdata_ff[bclc_pkg::STS_STATE_LSB +: 4]   <= state_ff;
          rdata_ff[bclc_pkg::STS_LIMIT_LSB +: 4]   <= limit_ff;
          rdata_ff[bclc_pkg::STS_DUTY_LSB +: 8]    <= duty;
          rdata_ff[bclc_pkg::STS_SENSE_BIT]        <= sns_s2_ff;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwm_s1_ff <= 1'b0;
      pwm_s2_ff <= 1'b0;
      pwm_d_ff  <= 1'b0;
      sns_s1_ff <= 1'b0;
      sns_s2_ff <= 1'b0;
    end else begin
      pwm_s1_ff <= pwm_pin;
      pwm_s2_ff <= pwm_s1_ff;
      pwm_d_ff  <= pwm_s2_ff;
      sns_s1_ff <= sense_over_pin;
      sns_s2_ff <= sns_s1_ff;
    end
  end

  assign pwm_rise = pwm_s2_ff && !pwm_d_ff;
  assign pwm_fall = !pwm_s2_ff && pwm_d_ff;

  ////////////////////////////////////////////////////////////////////////
  // threshold

  bclc_duty_meter #(
    .CNT_W (bclc_pkg::TIMER_W)
  ) u_duty (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pwm_lvl (pwm_s2_ff),
    .duty    (duty)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      limit_ff <= bclc_pkg::RST_LIMIT;
    else if (current_mode)
      limit_ff <= duty[7:4];
    else
      limit_ff <= cfg_ff.limit;
  end

  assign limit_code        = limit_ff;
  assign demag_comp_enable = cfg_ff.demag;

  ////////////////////////////////////////////////////////////////////////
  // timers

  assign fixed_mode   = (cfg_ff.mode == bclc_pkg::MODE_INDIRECT_V) ||
                        (cfg_ff.mode == bclc_pkg::MODE_SPEED);
  assign direct_mode  = (cfg_ff.mode == bclc_pkg::MODE_DIRECT_V);
  assign current_mode = (cfg_ff.mode == bclc_pkg::MODE_CURRENT);

  // comparator output already reaches this logic only through the synchroniser
  assign trip      = sns_s2_ff;
  assign off_start = (state_ff == bclc_pkg::ST_DRIVE) && trip;

  // same field feeds off-time in every mode and the bridge period in indirect and speed modes
  bclc_offtime_timer u_off (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (off_start),
    .n_val   (cfg_ff.period),
    .busy    (off_busy),
    .done    (off_done),
    .length  ()
  );

  // free-running bridge period in indirect and speed modes
  assign per_start = fixed_mode && comm_run && (!per_busy || per_done);

  bclc_offtime_timer u_per (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (per_start),
    .n_val   (cfg_ff.period),
    .busy    (per_busy),
    .done    (per_done),
    .length  (per_len)
  );

  assign on_prod = per_len * speed_duty;
  assign on_len  = on_prod[bclc_pkg::TIMER_W+7:8];
  assign on_over = fixed_mode && (on_cnt_ff >= on_len);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      on_cnt_ff <= '0;
    else if (cycle_start)
      on_cnt_ff <= bclc_pkg::TIMER_W'(1);
    else if (on_cnt_ff != '1)
      on_cnt_ff <= on_cnt_ff + bclc_pkg::TIMER_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////
  // chopper state machine

  always_comb begin
    unique case (cfg_ff.mode)
      bclc_pkg::MODE_DIRECT_V: cycle_start = pwm_rise;
      bclc_pkg::MODE_CURRENT:  cycle_start = 1'b0;
      default:                 cycle_start = per_start;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      bclc_pkg::ST_IDLE: begin
        if (comm_run)
          nxt_state = bclc_pkg::ST_WAIT;
      end
      bclc_pkg::ST_DRIVE: begin
        if (trip)
          nxt_state = bclc_pkg::ST_RECIRC;
        else if (direct_mode && pwm_fall)
          nxt_state = bclc_pkg::ST_WAIT;
        else if (on_over)
          nxt_state = bclc_pkg::ST_WAIT;
      end
      bclc_pkg::ST_RECIRC: begin
        // input edges within the off-time are ignored
        if (off_done) begin
          if (current_mode || (direct_mode && pwm_s2_ff))
            nxt_state = bclc_pkg::ST_DRIVE;
          else
            nxt_state = bclc_pkg::ST_WAIT;
        end
      end
      bclc_pkg::ST_WAIT: begin
        if (current_mode || cycle_start)
          nxt_state = bclc_pkg::ST_DRIVE;
      end
      default: nxt_state = bclc_pkg::ST_IDLE;
    endcase
    if (!comm_run)
      nxt_state = bclc_pkg::ST_IDLE;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      state_ff <= bclc_pkg::ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////////////
  // bridge configuration

  // low first on falling bemf, high first on rising bemf
  assign rec_low_auto = bemf_falling ^ zc_passed;

  always_comb begin
    nxt_bridge = '0;
    unique case (nxt_state)
      bclc_pkg::ST_DRIVE: nxt_bridge.drive = 1'b1;
      bclc_pkg::ST_RECIRC,
      bclc_pkg::ST_WAIT: begin
        unique case (cfg_ff.recirc)
          2'h1: nxt_bridge.rec_high = 1'b1;
          2'h2: nxt_bridge.rec_low  = 1'b1;
          2'h3: nxt_bridge.fast     = 1'b1;
          default: begin
            nxt_bridge.rec_low  = rec_low_auto;
            nxt_bridge.rec_high = !rec_low_auto;
          end
        endcase
      end
      default: ;
    endcase
  end

  // outputs from flip-flops so the drivers never see decode glitches
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      bridge_ff <= '0;
    else
      bridge_ff <= nxt_bridge;
  end

  assign bridge = bridge_ff;

endmodule : bclc_chopper

// ### core/bclc_duty_meter.sv
// Purpose: measures input pwm duty to eight bits
// Assumes: pwm level already synchronised
// Notes: one restoring division per input period
`timescale 1ns/100ps
module bclc_duty_meter #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // input level
  input  wire logic       pwm_lvl,
  // result
  output logic [7:0]      duty
);

  logic             lvl_d_ff;
  logic [CNT_W-1:0] hi_ff, per_ff, num_ff, div_ff;
  logic [CNT_W:0]   rem_ff;
  logic [7:0]       q_ff, duty_ff;
  logic [3:0]       step_ff;
  logic             rise;
  logic [CNT_W:0]   trial;

  assign rise  = pwm_lvl && !lvl_d_ff;
  assign trial = {rem_ff[CNT_W-1:0], 1'b0};
  assign duty  = duty_ff;

  // high and period counts saturate on very slow inputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lvl_d_ff <= 1'b0;
      hi_ff    <= '0;
      per_ff   <= '0;
    end else begin
      lvl_d_ff <= pwm_lvl;
      if (rise) begin
        hi_ff  <= CNT_W'(1);
        per_ff <= CNT_W'(1);
      end else begin
        if (pwm_lvl && hi_ff != '1)
          hi_ff <= hi_ff + CNT_W'(1);
        if (per_ff != '1)
          per_ff <= per_ff + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      num_ff  <= '0;
      div_ff  <= '0;
      rem_ff  <= '0;
      q_ff    <= '0;
      step_ff <= '0;
      duty_ff <= '0;
    end else if (rise && per_ff != '0) begin
      num_ff  <= hi_ff;
      div_ff  <= per_ff;
      rem_ff  <= {1'b0, hi_ff};
      q_ff    <= '0;
      step_ff <= 4'h8;
    end else if (step_ff != '0) begin
      step_ff <= step_ff - 4'h1;
      if (trial >= {1'b0, div_ff}) begin
        rem_ff <= trial - {1'b0, div_ff};
        q_ff   <= {q_ff[6:0], 1'b1};
      end else begin
        rem_ff <= trial;
        q_ff   <= {q_ff[6:0], 1'b0};
      end
      if (step_ff == 4'h1)
        duty_ff <= (num_ff >= div_ff) ? 8'hff : {q_ff[6:0], trial >= {1'b0, div_ff}};
    end
  end

endmodule : bclc_duty_meter

// ### core/bclc_offtime_timer.sv
// Purpose: one-shot timer of 20 us plus n steps of 1.6 us
// Assumes: start has priority and may retrigger in the done cycle
// Notes: done is a one-cycle pulse at expiry
`timescale 1ns/100ps
module bclc_offtime_timer #(
  parameter int BASE_CYC = bclc_pkg::OFF_BASE_CYC,
  parameter int STEP_CYC = bclc_pkg::OFF_STEP_CYC
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // control
  input  wire logic                       start,
  input  wire logic [4:0]                 n_val,
  // state
  output logic                            busy,
  output logic                            done,
  output logic [bclc_pkg::TIMER_W-1:0]    length
);

  logic [bclc_pkg::TIMER_W-1:0] cnt_ff;
  logic                         busy_ff;

  // zero field gives the bare base time
  assign length = bclc_pkg::TIMER_W'(BASE_CYC) +
                  bclc_pkg::TIMER_W'(STEP_CYC) * bclc_pkg::TIMER_W'(n_val);
  assign busy   = busy_ff;
  assign done   = busy_ff && (cnt_ff == '0);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
    end else if (start) begin
      cnt_ff  <= length - bclc_pkg::TIMER_W'(1);
      busy_ff <= 1'b1;
    end else if (done) begin
      busy_ff <= 1'b0;
    end else if (busy_ff) begin
      cnt_ff  <= cnt_ff - bclc_pkg::TIMER_W'(1);
    end
  end

endmodule : bclc_offtime_timer

// ### core/bclc_pkg.sv
// Purpose: shared constants and types of the current-limit chopper
// Assumes: 10 MHz sys_clk
// Notes: all sizes in one place
package bclc_pkg;

  // register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_CFG    = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // ctrl fields
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_DEMAG_BIT  = 2;
  localparam int CTRL_RECIRC_LSB = 3;
  // cfg fields
  localparam int CFG_PERIOD_LSB  = 0;
  localparam int CFG_LIMIT_LSB   = 8;
  // status fields
  localparam int STS_STATE_LSB   = 0;
  localparam int STS_LIMIT_LSB   = 8;
  localparam int STS_DUTY_LSB    = 16;
  localparam int STS_SENSE_BIT   = 24;

  // reset values
  localparam logic [1:0] RST_MODE   = 2'h0;
  localparam logic [1:0] RST_RECIRC = 2'h0;
  localparam logic [4:0] RST_PERIOD = 5'h00;
  localparam logic [3:0] RST_LIMIT  = 4'hf;

  // off-time timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int OFF_BASE_NS    = 20000;
  localparam int OFF_STEP_NS    = 1600;
  localparam int OFF_BASE_CYC   = (OFF_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_STEP_CYC   = (OFF_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W        = 16;

  typedef enum logic [1:0] {
    MODE_DIRECT_V   = 2'h0,
    MODE_INDIRECT_V = 2'h1,
    MODE_SPEED      = 2'h2,
    MODE_CURRENT    = 2'h3
  } bclc_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_DRIVE  = 4'h2,
    ST_RECIRC = 4'h4,
    ST_WAIT   = 4'h8
  } bclc_state_t;

  // bridge command towards the gate driver stage
  typedef struct packed {
    logic drive;
    logic rec_high;
    logic rec_low;
    logic fast;
  } bclc_bridge_t;

  typedef struct packed {
    logic [1:0] mode;
    logic       demag;
    logic [1:0] recirc;
    logic [4:0] period;
    logic [3:0] limit;
  } bclc_cfg_t;

endpackage : bclc_pkg

// ### tb/bclc_bridge_model.sv
// Purpose: bridge, winding and sense comparator model
// Assumes: current ramps RISE per drive cycle
// Notes: small RISE answers slowly, large promptly
`timescale 1ns/100ps
module bclc_bridge_model #(
  parameter int RISE  = 1,
  parameter int SCALE = 16
) (
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst,
  // bridge side
  input wire bclc_pkg::bclc_bridge_t bridge,
  input wire logic [3:0]             limit_code,
  output logic                       sense_over_pin
);
  logic [15:0] cur_ff;
  // decay while not driven, floor at zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= 16'h0000;
    end else if (bridge.drive) begin
      cur_ff <= cur_ff + 16'(RISE);
    end else if (cur_ff != 16'h0000) begin
      cur_ff <= cur_ff - 16'h0001;
    end
  end
  // threshold is (code+1) steps
  assign sense_over_pin = (cur_ff > 16'((int'(limit_code) + 1) * SCALE));
endmodule : bclc_bridge_model

// ### tb/bclc_chopper_assertions.sv
// Purpose: port checker of the current-limit chopper
// Assumes: config shadowed from accepted bus writes
// Notes: off-time checks only in current mode
`timescale 1ns/100ps
module bclc_chk (
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst,
  // bus
  input wire logic [3:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  // pins and controller
  input wire logic                   pwm_pin,
  input wire logic                   sense_over_pin,
  input wire logic                   comm_run,
  input wire logic                   bemf_falling,
  input wire logic                   zc_passed,
  input wire logic [7:0]             speed_duty,
  // outputs
  input wire bclc_pkg::bclc_bridge_t bridge,
  input wire logic [3:0]             limit_code,
  input wire logic                   demag_comp_enable
);
  logic [1:0]  mode_ff;
  logic [1:0]  rsel_ff;
  logic [4:0]  n_ff;
  logic [3:0]  lim_ff;
  logic [15:0] rcnt_ff;
  logic [15:0] pcnt_ff;
  logic        seen_ff;
  logic        acc;
  logic        rec;
  logic        cur;
  logic        fixp;
  logic [2:0]  rexp;
  logic [15:0] off_cyc;
  assign acc = avs_write & ~avs_waitrequest;
  assign rec = bridge.rec_high | bridge.rec_low | bridge.fast;
  assign cur = (mode_ff == 2'h3);
  assign fixp = (mode_ff == 2'h1) | (mode_ff == 2'h2);
  assign off_cyc = 16'(bclc_pkg::OFF_BASE_CYC + bclc_pkg::OFF_STEP_CYC * int'(n_ff));
  // auto path: low side first when bemf falls
  assign rexp = (rsel_ff == 2'h1) ? 3'h4 : (rsel_ff == 2'h2) ? 3'h2 : (rsel_ff == 2'h3) ? 3'h1 :
                {~(bemf_falling ^ zc_passed), bemf_falling ^ zc_passed, 1'b0};
  ////////////////////////////////////////
  // shadow config, so no hierarchy is needed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= 2'h0;
      rsel_ff <= 2'h0;
      n_ff    <= 5'h00;
      lim_ff  <= 4'hf;
    end else if (acc && avs_address == 4'h0) begin
      mode_ff <= avs_writedata[1:0];
      rsel_ff <= avs_writedata[4:3];
    end else if (acc && avs_address == 4'h4) begin
      n_ff   <= avs_writedata[4:0];
      lim_ff <= avs_writedata[11:8];
    end
  end
  // first period after a config change is partial
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rcnt_ff <= 16'h0000;
      pcnt_ff <= 16'h0000;
      seen_ff <= 1'b0;
    end else begin
      rcnt_ff <= rec ? rcnt_ff + 16'h0001 : 16'h0000;
      pcnt_ff <= $rose(bridge.drive) ? 16'h0001 : pcnt_ff + 16'h0001;
      seen_ff <= (acc || !comm_run) ? 1'b0 : (seen_ff | $rose(bridge.drive));
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_wait;
    (avs_read | avs_write) & avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_demag;
    acc && avs_address == 4'h0 |=> demag_comp_enable == $past(avs_writedata[2]);
  endproperty
  a_demag: assert property (p_demag) else $error("demag enable wrong");
  property p_limit;
    acc && avs_address == 4'h4 && !cur |-> ##[1:3] limit_code == lim_ff;
  endproperty
  a_limit: assert property (p_limit) else $error("limit code not field");
  property p_idle;
    !comm_run ##1 !comm_run |-> bridge == 4'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("bridge not idle");
  property p_trip;
    cur && comm_run && bridge.drive && sense_over_pin |-> ##[1:4] rec;
  endproperty
  a_trip: assert property (p_trip) else $error("no recirc after trip");
  property p_hold;
    cur && rec |-> rcnt_ff < off_cyc;
  endproperty
  a_hold: assert property (p_hold) else $error("recirc too long");
  property p_offlen;
    cur && comm_run && $past(comm_run, 3) && $fell(rec) |-> rcnt_ff == off_cyc && bridge.drive;
  endproperty
  a_offlen: assert property (p_offlen) else $error("off-time length wrong");
  property p_rsel;
    cur && rec |-> bridge == {1'b0, rexp};
  endproperty
  a_rsel: assert property (p_rsel) else $error("recirc path wrong");
  property p_period;
    fixp && seen_ff && comm_run && $rose(bridge.drive) |-> pcnt_ff == off_cyc;
  endproperty
  a_period: assert property (p_period) else $error("pwm period wrong");
  c_off: cover property (cur && $fell(rec));
  c_per: cover property (fixp && seen_ff && $rose(bridge.drive));
  c_auto: cover property (cur && rsel_ff == 2'h0 && rec);
endmodule : bclc_chk
bind bclc_chopper bclc_chk u_chk (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pwm_pin(pwm_pin), .sense_over_pin(sense_over_pin),
  .comm_run(comm_run), .bemf_falling(bemf_falling), .zc_passed(zc_passed),
  .speed_duty(speed_duty), .bridge(bridge), .limit_code(limit_code),
  .demag_comp_enable(demag_comp_enable));

// ### tb/tb_bclc_chopper.sv
// Purpose: self-checking bench of the current-limit chopper
// Assumes: 10 MHz clock, one wait state on the bus
// Notes: pwm input generated from pwm_hi and pwm_per
`timescale 1ns/100ps
module tb_bclc_chopper;
  logic                   sys_clk;
  logic                   rst;
  logic [3:0]             avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   pwm_pin;
  logic                   sense_over_pin;
  logic                   comm_run;
  logic                   bemf_falling;
  logic                   zc_passed;
  logic [7:0]             speed_duty;
  bclc_pkg::bclc_bridge_t bridge;
  logic [3:0]             limit_code;
  logic                   demag_comp_enable;
  logic [31:0]            rd;
  logic [3:0]             b;
  int                     num_errors;
  int                     check_count;
  int                     len;
  int                     pcnt;
  int                     pwm_hi;
  int                     pwm_per;
  logic [1:0]             rs [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
  logic [4:0]             nv [5] = '{5'h00, 5'h1f, 5'h13, 5'h00, 5'h00};
  logic [3:0]             eb [5] = '{4'h4, 4'h2, 4'h1, 4'h2, 4'h4};
  logic                   bf [5] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
  logic                   zp [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
  bclc_chopper dut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pwm_pin(pwm_pin), .sense_over_pin(sense_over_pin),
    .comm_run(comm_run), .bemf_falling(bemf_falling), .zc_passed(zc_passed),
    .speed_duty(speed_duty), .bridge(bridge), .limit_code(limit_code),
    .demag_comp_enable(demag_comp_enable));
  bclc_bridge_model u_model (
    .sys_clk(sys_clk), .rst(rst), .bridge(bridge), .limit_code(limit_code),
    .sense_over_pin(sense_over_pin));
  ////////////////////////////////////////
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    pcnt = (pcnt + 1 >= pwm_per) ? 0 : pcnt + 1;
    pwm_pin <= (pcnt < pwm_hi);
  end
  // one request; holds until waitrequest low, then a free edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // cycles for which drive stays at v
  task automatic lvl_len(input logic v, output int n);
    n = 0;
    while (bridge.drive === v && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : lvl_len
  task automatic get_rec(output int n, output logic [3:0] bb);
    n = 0;
    for (int t = 0; t < 3000 && bridge[2:0] === 3'h0; t++) @(posedge sys_clk);
    bb = bridge;
    while (bridge[2:0] !== 3'h0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask : get_rec
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end
  ////////////////////////////////////////
  initial begin
    {sys_clk, avs_read, avs_write, pwm_pin, comm_run, bemf_falling, zc_passed} = '0;
    {avs_address, avs_writedata, speed_duty, pcnt, pwm_hi, pwm_per} = '0;
    num_errors = 0;
    check_count = 0;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, 32'h0000_0f00);
    bus(1'b0, 4'hc, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b1, 4'h8, 32'h0000_0000);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(32'(rd[11:8]), 32'h0000_000f);
    $display("test registers done");
    bus(1'b1, 4'h0, 32'h0000_0004);
    chk(32'(demag_comp_enable), 32'h0000_0001);
    bus(1'b1, 4'h0, 32'h0000_0000);
    chk(32'(demag_comp_enable), 32'h0000_0000);
    $display("test demag done");
    pwm_per = 200;
    pwm_hi = 80;
    bus(1'b1, 4'h4, 32'h0000_0b00);
    comm_run <= 1'b1;
    lvl_len(1'b0, len);
    chk(32'(limit_code), 32'h0000_000b);
    lvl_len(1'b1, len);
    lvl_len(1'b0, len);
    lvl_len(1'b1, len);
    chk(32'(len), 32'd80);
    $display("test direct done");
    speed_duty <= 8'h80;
    for (int m = 1; m < 3; m++) begin
      bus(1'b1, 4'h4, 32'h0000_0b02);
      bus(1'b1, 4'h0, 32'(m));
      lvl_len(1'b1, len);
      lvl_len(1'b0, len);
      lvl_len(1'b1, len);
      chk(32'(len), 32'd116);
      lvl_len(1'b0, len);
      chk(32'(len), 32'd116);
    end
    $display("test fixed period done");
    comm_run <= 1'b0;
    bus(1'b1, 4'h0, 32'h0000_0003);
    repeat (1000) @(posedge sys_clk);
    chk(32'(limit_code), 32'h0000_0006);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(32'(rd[23:16]), 32'h0000_0066);
    $display("test duty done");
    for (int i = 0; i < 5; i++) begin
      comm_run <= 1'b0;
      bus(1'b1, 4'h4, {20'h0_0000, 4'hf, 3'h0, nv[i]});
      bus(1'b1, 4'h0, {27'h000_0000, rs[i], 1'h0, 2'h3});
      bemf_falling <= bf[i];
      zc_passed <= zp[i];
      comm_run <= 1'b1;
      lvl_len(1'b0, len);
      get_rec(len, b);
      chk(32'(b), 32'(eb[i]));
      chk(32'(len), 32'(bclc_pkg::OFF_BASE_CYC + bclc_pkg::OFF_STEP_CYC * int'(nv[i])));
      chk(32'(bridge.drive), 32'h0000_0001);
    end
    $display("test trips done");
    comm_run <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(32'(bridge), 32'h0000_0000);
    $display("test idle done");
    final_report();
  end
endmodule : tb_bclc_chopper
